// *** ibs_status.sv ***
`timescale 1ns/1ps
`include "ibs_params.svh"

// How it works
// - a start seen on the wires sets the bus activity flag
// - clock line low while module stopped also sets the bus activity flag
// - start request written together with the run bit while bus busy launches a repeated start
// - complete byte with unread data register sets overrun flag bit 11
// - during overrun the data register keeps the unread byte
// - during overrun incoming bits still shift into the shift register
// - reading the data register clears the overrun flag
// - processor reset or run bit cleared clears the overrun flag
// - a stop seen on the wires clears the bus activity flag
// - writing one to the bus activity flag clears it, zero does nothing
module ibs_status
	import ibs_pkg::*;
#(
	parameter int QTR_CYC = `IBS_QTR_CYC
)(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire ibs_pkg::ibs_ahb_req_s ahb_req,
	output      ibs_pkg::ibs_ahb_rsp_s ahb_rsp,
	input  wire logic          scl_i,
	input  wire logic          sda_i,
	output      ibs_pkg::ibs_pins_s    pins,
	output      logic          irq
);
	import ibs_pkg::*;

	localparam int RS_WAIT = QTR_CYC + 1;

	ibs_state_s  r;
	ibs_state_s  n;
	logic        acc;
	logic        rd_data_now;
	logic        wr_stat;
	logic        wr_mode;
	logic        wr_evt;
	logic        wr_mask;
	logic        tick;
	logic        start_det;
	logic        stop_det;
	logic        scl_rise;
	logic        byte_done;
	logic [7:0]  new_byte;
	logic [3:0]  evt_set;
	logic [31:0] rv;

	//////////////////////////////////////////////////////////////////////////////
	// next state of the whole block
	always_comb
	begin
		n = r;
		rv = '0;
		evt_set = '0;
		byte_done = 1'b0;
		// two-flop synchronisers, the third stage is the edge reference
		n.scl_s1 = scl_i;
		n.scl_s2 = r.scl_s1;
		n.scl_q  = r.scl_s2;
		n.sda_s1 = sda_i;
		n.sda_s2 = r.sda_s1;
		n.sda_q  = r.sda_s2;
		// divider enable for repeated start phases
		tick  = (r.div == 8'(QTR_CYC - 1));
		n.div = tick ? 8'h00 : 8'(r.div + 8'h01);
		// bus address phase; zero wait so hready is always ours
		acc = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
		n.ph_wr = acc && ahb_req.hwrite;
		n.ph_addr = ahb_req.haddr[7:0];
		rd_data_now = acc && !ahb_req.hwrite && (ahb_req.haddr[7:0] == `IBS_OFS_RXDATA);
		wr_stat = r.ph_wr && (r.ph_addr == `IBS_OFS_STATUS);
		wr_mode = r.ph_wr && (r.ph_addr == `IBS_OFS_MODE);
		wr_evt  = r.ph_wr && (r.ph_addr == `IBS_OFS_EVT);
		wr_mask = r.ph_wr && (r.ph_addr == `IBS_OFS_MASK);
		// read mux sampled in the address phase, held for the data phase
		case (ahb_req.haddr[7:0])
			`IBS_OFS_STATUS:
			begin
				rv[`IBS_BIT_BUSY] = r.busy;
				rv[`IBS_BIT_OVR]  = r.overrun;
			end
			`IBS_OFS_MODE:
			begin
				rv[`IBS_BIT_RUN] = r.run;
				rv[`IBS_BIT_START_REQ] = (r.rs != RS_IDLE);
			end
			`IBS_OFS_RXDATA:  rv[7:0] = r.data;
			`IBS_OFS_RXSHIFT: rv[7:0] = r.shift;
			`IBS_OFS_EVT:     rv[3:0] = r.evt;
			`IBS_OFS_MASK:    rv[3:0] = r.mask;
			default:          rv = '0; // unmapped reads zero
		endcase
		if (acc && !ahb_req.hwrite)
			n.rdata = rv;
		// bus conditions, only while clock line high
		start_det = r.scl_s2 && r.scl_q && r.sda_q && !r.sda_s2;
		stop_det  = r.scl_s2 && r.scl_q && !r.sda_q && r.sda_s2;
		scl_rise  = r.scl_s2 && !r.scl_q;
		new_byte  = {r.shift[6:0], r.sda_s2};
		// bit counter: eight data bits then the acknowledge slot
		if (start_det)
			n.bitcnt = 4'h0;
		else if (scl_rise && r.run && r.busy)
		begin
			if (r.bitcnt == 4'(`IBS_BITS_BYTE))
				n.bitcnt = 4'h0;
			else
			begin
				n.shift  = new_byte;
				n.bitcnt = 4'(r.bitcnt + 4'h1);
				byte_done = (r.bitcnt == 4'(`IBS_BITS_BYTE - 1));
			end
		end
		// reading the data register frees it
		if (rd_data_now)
		begin
			n.overrun   = 1'b0;
			n.data_full = 1'b0;
		end
		// a held-back byte lands one cycle after the read
		if (r.pending && !r.data_full)
		begin
			n.data      = r.shift;
			n.data_full = 1'b1;
			n.pending   = 1'b0;
		end
		// a fresh byte either lands or is held back as overrun
		if (byte_done)
		begin
			evt_set[`IBS_EVT_BYTE] = 1'b1;
			if (r.data_full && !rd_data_now)
			begin
				n.overrun = 1'b1;
				n.pending = 1'b1;
				evt_set[`IBS_EVT_OVR] = 1'b1;
			end
			else
			begin
				n.data      = new_byte;
				n.data_full = 1'b1;
				n.pending   = 1'b0;
			end
		end
		// control writes; the start request self-clears into the generator
		if (wr_mode)
		begin
			n.run = ahb_req.hwdata[`IBS_BIT_RUN];
			if (ahb_req.hwdata[`IBS_BIT_START_REQ] && r.busy && (r.rs == RS_IDLE)
				&& ahb_req.hwdata[`IBS_BIT_RUN])
			begin
				n.rs  = RS_REL_SDA;
				n.div = 8'h00;
			end
		end
		// repeated start: release data, raise clock, pull data, pull clock
		// idle is left alone so a launch landing on a tick is not lost
		if (tick && (r.rs != RS_IDLE))
		begin
			case (r.rs)
				RS_IDLE:    n.rs = RS_IDLE;
				RS_REL_SDA: n.rs = RS_SCL_HI;
				RS_SCL_HI:  n.rs = r.scl_s2 ? RS_SDA_LO : RS_SCL_HI; // waits out stretching
				RS_SDA_LO:  n.rs = RS_SCL_LO;
				RS_SCL_LO:  n.rs = RS_IDLE;
				default:    n.rs = RS_IDLE;
			endcase
		end
		// module held in reset while the run bit is low, from the clearing write on
		if (!n.run)
		begin
			n.overrun   = 1'b0;
			n.data_full = 1'b0;
			n.pending   = 1'b0;
			n.bitcnt    = 4'h0;
			n.rs        = RS_IDLE;
		end
		// bus activity flag: every set is applied last so it beats a clear
		if (wr_stat && ahb_req.hwdata[`IBS_BIT_BUSY])
			n.busy = 1'b0;
		if (stop_det)
			n.busy = 1'b0;
		if (!r.run)
			n.busy = 1'b0;
		if (start_det)
			n.busy = 1'b1;
		if (!r.run && !r.scl_s2)
			n.busy = 1'b1;
		// sticky events, write one to clear, a new event wins
		evt_set[`IBS_EVT_START] = start_det;
		evt_set[`IBS_EVT_STOP]  = stop_det;
		if (wr_evt)
			n.evt = r.evt & ~ahb_req.hwdata[3:0];
		n.evt = n.evt | evt_set;
		if (wr_mask)
			n.mask = ahb_req.hwdata[3:0];
	end

	//////////////////////////////////////////////////////////////////////////////
	// state register; wires idle high so synchronisers reset high
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r         <= '0;
			r.scl_s1  <= 1'b1;
			r.scl_s2  <= 1'b1;
			r.scl_q   <= 1'b1;
			r.sda_s1  <= 1'b1;
			r.sda_s2  <= 1'b1;
			r.sda_q   <= 1'b1;
			r.mask    <= `IBS_MASK_RST;
			r.run     <= `IBS_RUN_RST;
			r.rs      <= RS_IDLE;
		end
		else
			r <= n;
	end

	//////////////////////////////////////////////////////////////////////////////
	// outputs: the pins never drive high, only pull low or release
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp     = 1'b0;
	assign ahb_rsp.hrdata    = r.rdata;
	assign pins.scl_o    = 1'b0;
	assign pins.sda_o    = 1'b0;
	assign pins.scl_oe_n = !((r.rs == RS_REL_SDA) || (r.rs == RS_SCL_LO));
	assign pins.sda_oe_n = !((r.rs == RS_SDA_LO) || (r.rs == RS_SCL_LO));
	assign irq = |(r.evt & r.mask); // level while an unmasked event stands

	//////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_rs_req;
		wr_mode && ahb_req.hwdata[`IBS_BIT_START_REQ] && ahb_req.hwdata[`IBS_BIT_RUN]
			&& r.busy && (r.rs == RS_IDLE);
	endsequence
	sequence s_rs_pulls;
		(!pins.scl_oe_n && pins.sda_oe_n) ##[1:RS_WAIT] (pins.scl_oe_n && pins.sda_oe_n);
	endsequence
	sequence s_rd_pend;
		rd_data_now && r.pending && r.run;
	endsequence

	property p_start_busy;
		start_det |=> r.busy;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start did not set busy");

	property p_low_idle_busy;
		(!r.run && !r.scl_s2) |=> r.busy;
	endproperty
	a_low_idle_busy: assert property (p_low_idle_busy) else $error("low clock idle not busy");

	property p_restart;
		s_rs_req |=> s_rs_pulls;
	endproperty
	a_restart: assert property (p_restart) else $error("repeated start not driven");

	property p_ovr_set;
		(byte_done && r.data_full && !rd_data_now) |=> (r.overrun && r.pending);
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");

	property p_ovr_hold;
		(r.overrun && !rd_data_now) |=> $stable(r.data);
	endproperty
	a_ovr_hold: assert property (p_ovr_hold) else $error("data changed in overrun");

	property p_ovr_shift;
		(r.overrun && scl_rise && r.busy && r.run && !start_det && r.bitcnt < 4'h8)
			|=> (r.shift[0] == $past(r.sda_s2));
	endproperty
	a_ovr_shift: assert property (p_ovr_shift) else $error("shift stalled in overrun");

	property p_rd_clr;
		rd_data_now |=> !r.overrun;
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("read left overrun set");

	property p_run_clr;
		!r.run |=> !r.overrun;
	endproperty
	a_run_clr: assert property (p_run_clr) else $error("stopped module kept overrun");

	property p_stop_clr;
		stop_det |=> !r.busy;
	endproperty
	a_stop_clr: assert property (p_stop_clr) else $error("stop left busy set");

	property p_w1c;
		(wr_stat && ahb_req.hwdata[`IBS_BIT_BUSY] && !start_det && (r.run || r.scl_s2))
			|=> !r.busy;
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear busy");

	property p_pend_move;
		s_rd_pend |=> ##1 (r.data_full && !r.pending);
	endproperty
	a_pend_move: assert property (p_pend_move) else $error("pending byte not moved");

endmodule : ibs_status

// *** ibs_params.svh ***
`ifndef IBS_PARAMS_SVH
`define IBS_PARAMS_SVH

// register byte offsets
`define IBS_OFS_STATUS    8'h00
`define IBS_OFS_MODE      8'h04
`define IBS_OFS_RXDATA    8'h08
`define IBS_OFS_RXSHIFT   8'h0C
`define IBS_OFS_EVT       8'h10
`define IBS_OFS_MASK      8'h14

// field positions
`define IBS_BIT_BUSY      12
`define IBS_BIT_OVR       11
`define IBS_BIT_START_REQ 13
`define IBS_BIT_RUN       5
`define IBS_EVT_START     0
`define IBS_EVT_STOP      1
`define IBS_EVT_OVR       2
`define IBS_EVT_BYTE      3

// reset values
`define IBS_MASK_RST      4'h0
`define IBS_RUN_RST       1'b0

// timing: quarter of a 100 kHz bit period for the repeated start phases
`define IBS_CLK_PERIOD_NS 100
`define IBS_T_QTR_NS      2500
`define IBS_QTR_CYC       ((`IBS_T_QTR_NS + `IBS_CLK_PERIOD_NS - 1) / `IBS_CLK_PERIOD_NS)
`define IBS_BITS_BYTE     8

`endif

// *** ibs_pkg.sv ***
package ibs_pkg;

	// repeated start generator phases
	typedef enum logic [2:0] {
		RS_IDLE,
		RS_REL_SDA,
		RS_SCL_HI,
		RS_SDA_LO,
		RS_SCL_LO
	} ibs_rs_e;

	// ahb-lite slave request group
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ibs_ahb_req_s;

	// ahb-lite slave answer group
	typedef struct packed {
		logic        hreadyout;
		logic [31:0] hrdata;
		logic        hresp;
	} ibs_ahb_rsp_s;

	// two-wire pins, oe active low
	typedef struct packed {
		logic scl_o;
		logic scl_oe_n;
		logic sda_o;
		logic sda_oe_n;
	} ibs_pins_s;

	// whole state of the block
	typedef struct packed {
		logic        scl_s1;
		logic        scl_s2;
		logic        scl_q;
		logic        sda_s1;
		logic        sda_s2;
		logic        sda_q;
		logic        busy;
		logic        overrun;
		logic        data_full;
		logic        pending;
		logic        run;
		logic [7:0]  shift;
		logic [7:0]  data;
		logic [3:0]  bitcnt;
		logic [3:0]  evt;
		logic [3:0]  mask;
		logic [7:0]  div;
		ibs_rs_e     rs;
		logic        ph_wr;
		logic [7:0]  ph_addr;
		logic [31:0] rdata;
	} ibs_state_s;

endpackage : ibs_pkg

// *** ibs_bus_model.sv ***
`timescale 1ns/1ps
// two-wire master model; outputs are open drain, 1 pulls the wire low
module ibs_bus_model #(
	parameter int HALF = 6
)(
	input  wire logic hclk,
	output      logic scl_lo,
	output      logic sda_lo
);
	// both wires released at power up, the pull-ups hold them high
	initial
	begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic hold();
		repeat (HALF) @(posedge hclk);
	endtask : hold
	task automatic pull_scl(input logic v);
		scl_lo <= v;
	endtask : pull_scl
	// data falls while the clock is high
	task automatic start();
		sda_lo <= 1'b0;
		hold();
		scl_lo <= 1'b0;
		hold();
		sda_lo <= 1'b1;
		hold();
		scl_lo <= 1'b1;
		hold();
	endtask : start
	// data rises while the clock is high; clock pulled first so no edge is misread
	task automatic stop();
		scl_lo <= 1'b1;
		hold();
		sda_lo <= 1'b1;
		hold();
		scl_lo <= 1'b0;
		hold();
		sda_lo <= 1'b0;
		hold();
	endtask : stop
	// data let go before clock, otherwise the release reads as a stop
	task automatic rel();
		sda_lo <= 1'b0;
		hold();
		scl_lo <= 1'b0;
		hold();
	endtask : rel
	// msb first, ninth clock carries a released ack bit
	task automatic send(input logic [7:0] b);
		logic [8:0] s;
		s = {b, 1'b1};
		repeat (9)
		begin
			sda_lo <= ~s[8];
			s = s << 1;
			hold();
			scl_lo <= 1'b0;
			hold();
			scl_lo <= 1'b1;
		end
		hold();
	endtask : send
endmodule : ibs_bus_model

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import ibs_pkg::*;
	logic         hclk;
	logic         hresetn;
	ibs_ahb_req_s req;
	ibs_ahb_req_s req_in;
	ibs_ahb_rsp_s rsp;
	ibs_pins_s    pins;
	logic         irq;
	logic         scl_lo;
	logic         sda_lo;
	logic         scl_w;
	logic         sda_w;
	logic         hit;
	int           miscompares;
	int           tests_run;
	////////////////////////////////////////////////////////////////////////
	// wired-and with pull-ups; design pulls low when its enable is low
	assign scl_w = ~(scl_lo | ~pins.scl_oe_n);
	assign sda_w = ~(sda_lo | ~pins.sda_oe_n);
	// single slave, so its ready is the bus ready
	always_comb
	begin
		req_in = req;
		req_in.hready = rsp.hreadyout;
	end
	ibs_status #(
		.QTR_CYC (4)
	) dut_u (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ahb_req (req_in),
		.ahb_rsp (rsp),
		.scl_i   (scl_w),
		.sda_i   (sda_w),
		.pins    (pins),
		.irq     (irq)
	);
	ibs_bus_model bm_u (
		.hclk   (hclk),
		.scl_lo (scl_lo),
		.sda_lo (sda_lo)
	);
	////////////////////////////////////////////////////////////////////////
	// 100 ns clock
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk
	// one transfer; address phase held until ready, then data phase until ready
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdv);
		int n;
		req.hsel <= 1'b1;
		req.htrans <= 2'b10;
		req.hwrite <= w;
		req.hsize <= 3'h2;
		req.haddr <= {24'h0, a};
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (rsp.hreadyout !== 1'b1 && n < 50);
		req.htrans <= 2'b00;
		req.hwdata <= wd;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (rsp.hreadyout !== 1'b1 && n < 100);
		rdv = rsp.hrdata;
		if (n >= 100)
		begin
			miscompares++;
			print_verdict();
		end
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk(exp, x);
	endtask : rdc
	// hang guard
	initial
	begin
		repeat (60000) @(posedge hclk);
		miscompares++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		req = '0;
		hresetn = 1'b0;
		miscompares = 0;
		tests_run = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(8'h00, 32'h0);
		rdc(8'h14, 32'h0);
		rdc(8'h40, 32'h0);
		bm_u.pull_scl(1'b1);
		repeat (10) @(posedge hclk);
		rdc(8'h00, 32'h1000);
		bm_u.pull_scl(1'b0);
		repeat (10) @(posedge hclk);
		rdc(8'h00, 32'h0);
		wr(8'h04, 32'h20);
		rdc(8'h04, 32'h20);
		bm_u.start();
		rdc(8'h00, 32'h1000);
		rdc(8'h10, 32'h1);
		wr(8'h00, 32'h0);
		rdc(8'h00, 32'h1000);
		wr(8'h00, 32'h1000);
		rdc(8'h00, 32'h0);
		bm_u.start();
		bm_u.rel();
		wr(8'h04, 32'h2020);
		rdc(8'h04, 32'h2020);
		hit = 1'b0;
		// look for the data line driven low while the clock wire is high
		for (int i = 0; i < 200; i++)
		begin
			@(posedge hclk);
			if (pins.sda_oe_n === 1'b0 && scl_w === 1'b1)
				hit = 1'b1;
		end
		chk(32'h1, {31'h0, hit});
		chk(32'h0, {29'h0, rsp.hresp, pins.scl_o, pins.sda_o});
		bm_u.stop();
		rdc(8'h00, 32'h0);
		wr(8'h14, 32'h4);
		// first pass clears overrun by a data read, second by stopping the module
		for (int k = 0; k < 2; k++)
		begin
			bm_u.start();
			bm_u.send(8'hA5);
			bm_u.send(8'h3C);
			rdc(8'h00, 32'h1800);
			chk(32'h1, {31'h0, irq});
			rdc(8'h0C, 32'h3C);
			if (k == 0)
			begin
				rdc(8'h08, 32'hA5);
				rdc(8'h00, 32'h1000);
				rdc(8'h08, 32'h3C);
				wr(8'h10, 32'h4);
				// the clear lands at the edge that ended the write; look one edge later
				@(posedge hclk);
				chk(32'h0, {31'h0, irq});
				bm_u.stop();
			end
			else
			begin
				bm_u.stop();
				wr(8'h04, 32'h0);
				rdc(8'h00, 32'h0);
			end
		end
		print_verdict();
	end
endmodule : tb_top
